// ---- agsa_pkg.sv ----
// constants, operation forms and timing for the shifted add and
// stack long-align datapath.
// assumes a 24-bit address space and a 16-bit data memory word.
package agsa_pkg;

    localparam int ADDR_W = 24;
    localparam int WORD_W = 16;
    localparam int IMM_HI_W = 8;
    localparam int CNT_W = 3;
    localparam int IDX_W = 3;

    // operation forms presented by the decoder
    typedef enum logic [2:0] {
        AGSA_REG_REG,
        AGSA_REG_REG_OFS,
        AGSA_IMM16_REG,
        AGSA_IMM24_REG,
        AGSA_IMM16_DATA,
        AGSA_IMM24_DATA,
        AGSA_LONG_ALIGN
    } agsa_op_e;

    // execution cycles per form
    localparam logic [CNT_W-1:0] CYC_REG = 3'h1;
    localparam logic [CNT_W-1:0] CYC_IMM16 = 3'h2;
    localparam logic [CNT_W-1:0] CYC_IMM24 = 3'h3;
    localparam logic [CNT_W-1:0] CYC_DATA16 = 3'h4;
    localparam logic [CNT_W-1:0] CYC_DATA24 = 3'h5;
    localparam logic [CNT_W-1:0] CYC_ALIGN = 3'h3;

    // program words per form
    localparam logic [1:0] WORDS_REG = 2'h1;
    localparam logic [1:0] WORDS_IMM16 = 2'h2;
    localparam logic [1:0] WORDS_IMM24 = 2'h3;
    localparam logic [1:0] WORDS_ALIGN = 2'h1;

    // stack pointer steps
    localparam logic [ADDR_W-1:0] STACK_STEP_ODD = 24'h000002;
    localparam logic [ADDR_W-1:0] STACK_STEP_EVEN = 24'h000003;
    localparam logic [ADDR_W-1:0] STACK_STEP_POST = 24'h000002;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

endpackage

// ---- agsa_add_if.sv ----
// operand and sum bundle between the control module and the adder.
// assumes both ends share the same 24-bit address width.
`timescale 1ns/1ps
`default_nettype none
interface agsa_add_if;
    import agsa_pkg::*;
    logic [ADDR_W-1:0] opa;
    logic [ADDR_W-1:0] opb;
    logic              dbl;
    logic [ADDR_W-1:0] sum;
    modport user (output opa, output opb, output dbl, input sum);
    modport unit (input opa, input opb, input dbl, output sum);
endinterface
`default_nettype wire

// ---- agsa_adder.sv ----
// 24-bit address adder with optional one-bit left shift of operand a.
// assumes operands are already extended to 24 bits by the caller.
`timescale 1ns/1ps
`default_nettype none
module agsa_adder
    import agsa_pkg::*;
(
    agsa_add_if.unit add
);
    logic [ADDR_W-1:0] shifted;
    logic [ADDR_W:0]   full;

    // bit 23 falls off the shift, and the carry is never kept
    assign shifted = add.dbl ? {add.opa[ADDR_W-2:0], 1'b0} : add.opa;
    assign full = {1'b0, shifted} + {1'b0, add.opb};
    assign add.sum = full[ADDR_W-1:0];
endmodule
`default_nettype wire

// ---- agsa_core.sv ----
// shifted address add and stack long-align execution datapath.
// assumes the decoder holds start and operands for one cycle while
// busy is low, and the memory port takes one word per write strobe.
`timescale 1ns/1ps
`default_nettype none
module agsa_core
    import agsa_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              start,
    input  wire agsa_op_e          op,
    input  wire logic              two_operand,
    input  wire logic [IDX_W-1:0]  src2_idx,
    input  wire logic [IDX_W-1:0]  dest_idx,
    input  wire logic [ADDR_W-1:0] shift_src,
    input  wire logic [ADDR_W-1:0] add_src,
    input  wire logic [WORD_W-1:0] data_reg_source,
    input  wire logic [WORD_W-1:0] imm_lo,
    input  wire logic [IMM_HI_W-1:0] imm_hi,
    input  wire logic [ADDR_W-1:0] stack_pointer_in,
    output logic                   busy,
    output logic                   result_valid,
    output logic [ADDR_W-1:0]      result,
    output logic [IDX_W-1:0]       result_dest,
    output logic                   result_to_offset,
    output logic [1:0]             instr_words,
    output logic                   cc_write,
    output logic                   mem_we,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [WORD_W-1:0]      mem_wdata,
    output logic                   stack_pointer_we,
    output logic [ADDR_W-1:0]      stack_pointer_out
);

    typedef enum logic [1:0] {
        S_IDLE,
        S_ADD_WAIT,
        S_ALN_HI,
        S_ALN_LO
    } agsa_state_e;

    agsa_state_e       state_reg;
    agsa_state_e       state_next;
    logic [CNT_W-1:0]  cnt_reg;
    logic [ADDR_W-1:0] adj_reg;
    logic [ADDR_W-1:0] orig_reg;
    logic [ADDR_W-1:0] result_reg;
    logic              valid_reg;
    logic [IDX_W-1:0]  dest_reg;
    logic              ofs_reg;
    logic [1:0]        words_reg;
    logic              busy_reg;
    logic              cc_reg;
    logic              we_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [WORD_W-1:0] wdata_reg;
    logic              stack_we_reg;
    logic [ADDR_W-1:0] stack_reg;

    agsa_add_if add ();
    agsa_adder u_adder (.add(add));

    // operand decoding
    wire take = start && (state_reg == S_IDLE);
    wire is_align = (op == AGSA_LONG_ALIGN);
    wire is_data = (op == AGSA_IMM16_DATA) || (op == AGSA_IMM24_DATA);
    wire is_imm16 = (op == AGSA_IMM16_REG) || (op == AGSA_IMM16_DATA);
    wire is_imm24 = (op == AGSA_IMM24_REG) || (op == AGSA_IMM24_DATA);
    wire is_reg = (op == AGSA_REG_REG) || (op == AGSA_REG_REG_OFS);
    wire [ADDR_W-1:0] data_ext =
        {{(ADDR_W-WORD_W){data_reg_source[WORD_W-1]}},
         data_reg_source};
    wire [ADDR_W-1:0] imm16_ext =
        {{(ADDR_W-WORD_W){1'b0}}, imm_lo};
    wire [ADDR_W-1:0] imm24_val = {imm_hi, imm_lo};
    wire [ADDR_W-1:0] add_opb =
        is_imm16 ? imm16_ext : (is_imm24 ? imm24_val : add_src);
    wire [ADDR_W-1:0] shift_opa =
        is_data ? data_ext : shift_src;
    wire [ADDR_W-1:0] align_step =
        stack_pointer_in[0] ? STACK_STEP_ODD
                            : STACK_STEP_EVEN;

    // one adder serves both operations; they never overlap in time
    assign add.opa = (state_reg == S_ALN_HI) ? adj_reg
                   : (is_align ? stack_pointer_in : shift_opa);
    assign add.opb = (state_reg == S_ALN_HI) ? STACK_STEP_POST
                   : (is_align ? align_step : add_opb);
    assign add.dbl = (state_reg == S_IDLE) && !is_align;

    wire [CNT_W-1:0] op_cycles =
        is_reg ? CYC_REG
      : (op == AGSA_IMM16_REG) ? CYC_IMM16
      : (op == AGSA_IMM24_REG) ? CYC_IMM24
      : (op == AGSA_IMM16_DATA) ? CYC_DATA16
      : (op == AGSA_IMM24_DATA) ? CYC_DATA24
      : CYC_ALIGN;
    wire [1:0] op_words =
        is_align ? WORDS_ALIGN
      : is_imm16 ? WORDS_IMM16
      : is_imm24 ? WORDS_IMM24
      : WORDS_REG;
    wire [IDX_W-1:0] op_dest =
        two_operand ? src2_idx : dest_idx;
    wire [ADDR_W-1:0] low_word_addr = adj_reg - ADDR_W'(1);
    wire [WORD_W-1:0] orig_hi =
        {{(2*WORD_W-ADDR_W){1'b0}}, orig_reg[ADDR_W-1:WORD_W]};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (take && is_align) begin
                    state_next = S_ALN_HI;
                end else if (take && op_cycles != CYC_REG) begin
                    state_next = S_ADD_WAIT;
                end
            end
            S_ADD_WAIT: begin
                if (cnt_reg == 3'h1) begin
                    state_next = S_IDLE;
                end
            end
            S_ALN_HI: state_next = S_ALN_LO;
            S_ALN_LO: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            cnt_reg <= 3'h0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (take) begin
                cnt_reg <= op_cycles - 3'h1;
            end else if (cnt_reg != 3'h0) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
            busy_reg <= (state_next != S_IDLE);
        end
    end

    // shifted add result and its destination
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            result_reg <= ADDR_RST;
            dest_reg <= 3'h0;
            ofs_reg <= 1'b0;
            words_reg <= 2'h0;
        end else if (take) begin
            if (!is_align) begin
                result_reg <= add.sum;
                dest_reg <= op_dest;
                ofs_reg <= (op == AGSA_REG_REG_OFS);
            end
            words_reg <= op_words;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= (take && !is_align && op_cycles == CYC_REG)
                      || (state_reg == S_ADD_WAIT && cnt_reg == 3'h1);
        end
    end

    // stack long-align sequence
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            adj_reg <= ADDR_RST;
            orig_reg <= ADDR_RST;
        end else if (take && is_align) begin
            adj_reg <= add.sum;
            orig_reg <= stack_pointer_in;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            we_reg <= 1'b0;
            addr_reg <= ADDR_RST;
            wdata_reg <= WORD_RST;
            stack_we_reg <= 1'b0;
            stack_reg <= ADDR_RST;
        end else begin
            we_reg <= (state_reg == S_ALN_HI) || (state_reg == S_ALN_LO);
            stack_we_reg <= (state_reg == S_ALN_LO);
            if (state_reg == S_ALN_HI) begin
                addr_reg <= adj_reg;
                wdata_reg <= orig_hi;
                stack_reg <= add.sum;
            end else if (state_reg == S_ALN_LO) begin
                addr_reg <= low_word_addr;
                wdata_reg <= orig_reg[WORD_W-1:0];
            end
        end
    end

    // status flags are never written by either operation
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cc_reg <= 1'b0;
        end else begin
            cc_reg <= 1'b0;
        end
    end

    assign busy = busy_reg;
    assign result_valid = valid_reg;
    assign result = result_reg;
    assign result_dest = dest_reg;
    assign result_to_offset = ofs_reg;
    assign instr_words = words_reg;
    assign cc_write = cc_reg;
    assign mem_we = we_reg;
    assign mem_addr = addr_reg;
    assign mem_wdata = wdata_reg;
    assign stack_pointer_we = stack_we_reg;
    assign stack_pointer_out = stack_reg;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence aln_hi_write;
        mem_we && mem_addr == $past(adj_reg);
    endsequence
    sequence aln_lo_write;
        mem_we && stack_pointer_we && mem_addr == $past(mem_addr) - 24'h1;
    endsequence

    a_align_writes: assert property (
        take && is_align |-> ##2 aln_hi_write ##1 aln_lo_write)
        else $error("long-align memory writes out of order");
    // take may share its edge with the previous align's pointer strobe
    a_align_three: assert property (
        take && is_align |-> ##1 !stack_pointer_we [*2] ##1 stack_pointer_we)
        else $error("long-align did not finish in three cycles");
    a_stack_odd: assert property (
        stack_pointer_we |-> stack_pointer_out[0])
        else $error("stack pointer left even after align");
    a_stack_value: assert property (
        stack_pointer_we |-> stack_pointer_out == 24'(orig_reg
            + (orig_reg[0] ? 24'h4 : 24'h5)))
        else $error("aligned stack pointer has wrong value");
    a_reg_sum: assert property (
        take && op == AGSA_REG_REG |-> ##1 result_valid
        && result == 24'(($past(shift_src) << 1) + $past(add_src)))
        else $error("register shifted add wrong");
    a_offset_only: assert property (
        take && op == AGSA_REG_REG_OFS |-> ##1 result_to_offset)
        else $error("offset form did not target offset");
    a_short_zext: assert property (
        take && op == AGSA_IMM16_REG |-> ##2 result_valid
        && result == 24'(($past(shift_src, 2) << 1) + $past(imm_lo, 2)))
        else $error("short immediate shifted add wrong");
    a_long_sum: assert property (
        take && op == AGSA_IMM24_REG |-> ##3 result_valid
        && result == 24'(($past(shift_src, 3) << 1)
            + {$past(imm_hi, 3), $past(imm_lo, 3)}))
        else $error("long immediate shifted add wrong");
    a_data_sext: assert property (
        take && op == AGSA_IMM16_DATA |-> ##4 result_valid
        && result == 24'(({{8{$past(data_reg_source[15], 4)}},
            $past(data_reg_source, 4)} << 1) + $past(imm_lo, 4)))
        else $error("signed data source add wrong");
    a_long_imm: assert property (
        take && op == AGSA_IMM24_DATA |-> ##1 !result_valid [*4]
        ##1 result_valid)
        else $error("long data form latency wrong");
    a_two_op_dest: assert property (
        take && two_operand && !is_align |-> ##1 result_dest == $past(src2_idx))
        else $error("two-operand destination wrong");
    a_cc_quiet: assert property (
        busy || result_valid |-> !cc_write)
        else $error("condition codes written");

endmodule
`default_nettype wire

// ---- agsa_mem_model.sv ----
// data memory port model standing beside the align datapath.
// assumes one 16-bit word is written per cycle that the strobe is high.
`timescale 1ns/1ps
`default_nettype none
module agsa_mem_model
    import agsa_pkg::*;
(
    input wire logic              clock,
    input wire logic              we,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wdata
);
    logic [WORD_W-1:0] mem [logic [ADDR_W-1:0]];
    int                writes = 0;

    // a long word arrives as two separate word strobes
    always @(posedge clock) begin
        if (we === 1'b1) begin
            mem[addr] = wdata;
            writes++;
        end
    end
endmodule
`default_nettype wire

// ---- tb_agsa_core.sv ----
// self-checking bench for the shifted add and stack long-align core.
// assumes agsa_pkg, agsa_core and agsa_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_agsa_core
    import agsa_pkg::*;
    ;
    logic clock = 1'b0;
    logic rstn, start, two_operand;
    agsa_op_e op;
    logic [IDX_W-1:0] src2_idx, dest_idx, result_dest;
    logic [ADDR_W-1:0] shift_src, add_src, stack_pointer_in;
    logic [WORD_W-1:0] data_reg_source, imm_lo, mem_wdata;
    logic [IMM_HI_W-1:0] imm_hi;
    logic busy, result_valid, result_to_offset, cc_write, mem_we;
    logic stack_pointer_we;
    logic [ADDR_W-1:0] result, mem_addr, stack_pointer_out;
    logic [1:0] instr_words;
    logic [23:0] v_s, v_a, e1;
    logic [15:0] v_d, v_lo;
    logic [7:0] v_hi;
    logic v_two;
    logic [2:0] v_i2, v_id;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    always #2.5 clock = ~clock;

    agsa_core u_agsa_core (.clock(clock), .rstn(rstn), .start(start),
        .op(op), .two_operand(two_operand), .src2_idx(src2_idx),
        .dest_idx(dest_idx), .shift_src(shift_src), .add_src(add_src),
        .data_reg_source(data_reg_source), .imm_lo(imm_lo),
        .imm_hi(imm_hi), .stack_pointer_in(stack_pointer_in),
        .busy(busy), .result_valid(result_valid), .result(result),
        .result_dest(result_dest), .result_to_offset(result_to_offset),
        .instr_words(instr_words), .cc_write(cc_write), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .stack_pointer_we(stack_pointer_we),
        .stack_pointer_out(stack_pointer_out));

    agsa_mem_model u_agsa_mem_model (.clock(clock), .we(mem_we),
        .addr(mem_addr), .wdata(mem_wdata));

    task conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // whole run is a few hundred cycles; this only catches a hang
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [23:0] exp_sum(agsa_op_e o);
        logic [23:0] imm, base;
        imm = {8'h00, v_lo};
        if (o == AGSA_IMM24_REG || o == AGSA_IMM24_DATA)
            imm = {v_hi, v_lo};
        if (o == AGSA_REG_REG || o == AGSA_REG_REG_OFS)
            imm = v_a;
        base = v_s;
        if (o == AGSA_IMM16_DATA || o == AGSA_IMM24_DATA)
            base = {{8{v_d[15]}}, v_d};
        return (base << 1) + imm;
    endfunction

    function automatic logic [23:0] exp_cyc(agsa_op_e o);
        case (o)
            AGSA_IMM16_REG:  return 24'h2;
            AGSA_IMM24_REG:  return 24'h3;
            AGSA_IMM16_DATA: return 24'h4;
            AGSA_IMM24_DATA: return 24'h5;
            default:         return 24'h1;
        endcase
    endfunction

    function automatic logic [23:0] exp_words(agsa_op_e o);
        if (o == AGSA_IMM16_REG || o == AGSA_IMM16_DATA)
            return 24'h2;
        if (o == AGSA_IMM24_REG || o == AGSA_IMM24_DATA)
            return 24'h3;
        return 24'h1;
    endfunction

    task rnd();
        v_s = 24'($urandom);
        v_a = 24'($urandom);
        v_d = 16'($urandom);
        v_lo = 16'($urandom);
        v_hi = 8'($urandom);
        v_two = 1'($urandom);
        v_i2 = 3'($urandom);
        v_id = 3'($urandom);
    endtask

    task drive(input agsa_op_e o);
        start <= 1'b1;
        op <= o;
        shift_src <= v_s;
        add_src <= v_a;
        data_reg_source <= v_d;
        imm_lo <= v_lo;
        imm_hi <= v_hi;
        two_operand <= v_two;
        src2_idx <= v_i2;
        dest_idx <= v_id;
    endtask

    // poke presents a second start while the first is still busy
    task run_add(input agsa_op_e o, input logic poke);
        int n;
        n = 0;
        @(posedge clock);
        drive(o);
        do begin
            @(posedge clock);
            n++;
            if (n == 1)
                start <= 1'b0;
            if (poke && n == 2) begin
                start <= 1'b1;
                op <= AGSA_REG_REG;
                shift_src <= ~v_s;
            end
            if (poke && n == 3)
                start <= 1'b0;
            #1;
            if (n == 1)
                chk({23'h0, busy}, 24'(exp_cyc(o) > 24'h1));
        end while (result_valid !== 1'b1 && n < 8);
        chk(24'(n), exp_cyc(o));
        chk({23'h0, busy}, 24'h0);
        chk(result, exp_sum(o));
        chk({21'h0, result_dest}, {21'h0, v_two ? v_i2 : v_id});
        chk({23'h0, result_to_offset}, {23'h0, o == AGSA_REG_REG_OFS});
        chk({22'h0, instr_words}, exp_words(o));
        chk({23'h0, cc_write}, 24'h0);
        if (poke) begin
            repeat (3) begin
                @(posedge clock);
                #1;
                chk({23'h0, result_valid}, 24'h0);
            end
        end
    endtask

    task run_align(input logic [23:0] sp);
        logic [23:0] adj;
        int n, w0;
        adj = sp + (sp[0] ? 24'h2 : 24'h3);
        w0 = u_agsa_mem_model.writes;
        n = 0;
        @(posedge clock);
        start <= 1'b1;
        op <= AGSA_LONG_ALIGN;
        stack_pointer_in <= sp;
        do begin
            @(posedge clock);
            n++;
            if (n == 1)
                start <= 1'b0;
            #1;
        end while (stack_pointer_we !== 1'b1 && n < 8);
        chk(24'(n), 24'h3);
        chk({23'h0, busy}, 24'h0);
        chk(stack_pointer_out, adj + 24'h2);
        chk({23'h0, stack_pointer_out[0]}, 24'h1);
        chk({22'h0, instr_words}, 24'h1);
        chk({23'h0, cc_write}, 24'h0);
        @(posedge clock);
        #1;
        chk({8'h0, u_agsa_mem_model.mem[adj]}, {16'h0, sp[23:16]});
        chk({8'h0, u_agsa_mem_model.mem[adj - 24'h1]}, {8'h0, sp[15:0]});
        chk(24'(u_agsa_mem_model.writes - w0), 24'h2);
    endtask

    initial begin
        rstn = 1'b0;
        start = 1'b0;
        op = AGSA_REG_REG;
        stack_pointer_in = 24'h0;
        v_s = 24'h800001;
        v_a = 24'hffffff;
        v_d = 16'h8000;
        v_lo = 16'hffff;
        v_hi = 8'hff;
        v_two = 1'b0;
        v_i2 = 3'h5;
        v_id = 3'h2;
        shift_src = v_s;
        add_src = v_a;
        data_reg_source = v_d;
        imm_lo = v_lo;
        imm_hi = v_hi;
        two_operand = v_two;
        src2_idx = v_i2;
        dest_idx = v_id;
        void'($urandom(32'h6b4e07a3));
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        chk({20'h0, busy, result_valid, mem_we, stack_pointer_we}, 24'h0);
        // carry out of bit 23, negative data word, all-ones immediates
        for (int i = 0; i < 6; i++)
            run_add(agsa_op_e'(i), 1'b0);
        $display("test corners done");
        repeat (40) begin
            rnd();
            run_add(agsa_op_e'($urandom_range(5, 0)), 1'b0);
        end
        $display("test random forms done");
        rnd();
        run_add(AGSA_IMM24_DATA, 1'b1);
        $display("test start while busy done");
        rnd();
        v_two = 1'b0;
        e1 = exp_sum(AGSA_REG_REG);
        @(posedge clock);
        drive(AGSA_REG_REG);
        @(posedge clock);
        op <= AGSA_REG_REG_OFS;
        shift_src <= v_a;
        add_src <= v_s;
        #1;
        chk(result, e1);
        chk({23'h0, result_to_offset}, 24'h0);
        @(posedge clock);
        start <= 1'b0;
        #1;
        @(posedge clock);
        #1;
        chk(result, (v_a << 1) + v_s);
        chk({23'h0, result_to_offset}, 24'h1);
        $display("test back to back done");
        run_align(24'h001001);
        run_align(24'h001000);
        run_align(24'hffffff);
        run_align(24'hfffffe);
        repeat (4)
            run_align(24'($urandom));
        $display("test stack align done");
        conclude();
    end
endmodule
`default_nettype wire
